// File: dv/halt_and_reset_sequencer_test.sv
// Self-checking bench for the halt and reset sequencer.
// Assumes the far-side model and a shortened stabilisation count.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module halt_and_reset_sequencer_test;
    localparam int STAB = 10;
    logic clk, rst_n, haltExec, resetPinN, watchdogOverflow;
    logic [5:0] req;
    logic [7:0] vecData;
    logic [15:0] vecAddr, pcValue;
    logic cpuClkEn, periphClkEn, oscEn, mainOscEn, sub2OscEn, sub1OscEn, pinOutEnable;
    logic portLatchHold, ramRetain, coreResetN, pcLoad, vectorIrq, resumeNext, wdN;
    logic [95:0] rv;
    int fails = 0;
    int nCompared = 0;
    int k;
    halt_and_reset_sequencer #(.STAB_CYCLES(STAB)) dut (.clk(clk), .rst_n(rst_n),
        .resetPinN(resetPinN), .watchdogOverflow(watchdogOverflow), .haltExec(haltExec),
        .nmiRequest(req[5]), .irqRequest(req[4]), .irq_mask_flag(req[3]),
        .irq_priority_level_flag(req[2]), .irq_accept_enable(req[1]),
        .in_service_priority_flag(req[0]), .vecData(vecData), .vecAddr(vecAddr),
        .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .oscEn(oscEn), .mainOscEn(mainOscEn),
        .sub2OscEn(sub2OscEn), .sub1OscEn(sub1OscEn), .pinOutEnable(pinOutEnable),
        .portLatchHold(portLatchHold), .ramRetain(ramRetain), .coreResetN(coreResetN),
        .pcLoad(pcLoad), .pcValue(pcValue), .vectorIrq(vectorIrq), .resumeNext(resumeNext),
        .watchdog_overflow_outN(wdN), .cpu_clock_control(rv[95:88]),
        .program_status_word(rv[87:80]), .portLatchRst(rv[79:72]), .portModeRst(rv[71:64]),
        .pullUpRst(rv[63:56]), .memory_size_select(rv[55:48]),
        .expansion_ram_size_select(rv[47:40]), .clkOutSelect(rv[39:32]),
        .sub2Control(rv[31:24]), .timer0_count(rv[23:8]), .timer0Control(rv[7:0]));
    hrs_far_side #(.VEC(16'h1A2B)) far (.clk(clk), .vecAddr(vecAddr), .vecData(vecData),
        .resetPinN(resetPinN), .watchdogOverflow(watchdogOverflow), .req(req));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Counts edges to the vector load from k0 edges already gone since reset was released.
    // Pins may drive once the wait is over, while the vector bytes are still read.
    task automatic checkBoot(input int k0);
        int firstOut;
        firstOut = 0;
        k = k0;
        while (pcLoad !== 1'b1 && k < 300) begin
            @(posedge clk) #1;
            k++;
            if (firstOut == 0 && pinOutEnable === 1'b1) firstOut = k;
        end
        if (k >= 300) begin
            fails++;
            complete_run();
        end else begin
            `CHK(firstOut > STAB, 1'b1)
            `CHK(k > STAB, 1'b1)
            `CHK(pcValue, 16'h1A2B)
            `CHK({coreResetN, cpuClkEn, pinOutEnable}, 3'h7)
        end
    endtask
    task automatic haltNow();
        @(posedge clk) haltExec <= 1'b1;
        @(posedge clk) haltExec <= 1'b0;
        #1;
        `CHK({cpuClkEn, oscEn, periphClkEn, portLatchHold}, 4'h7)
    endtask
    // First edge after the request changes is the wake edge (k = 1); the registered
    // pulse shows 8 edges later when vectored, 2 edges later when resuming
    task automatic wake(input logic [5:0] r, input logic expVec);
        far.setReq(r);
        for (k = 1; k < 16; k++) begin
            @(posedge clk) #1;
            if (vectorIrq === 1'b1 || resumeNext === 1'b1) break;
        end
        `CHK(k, expVec ? 9 : 3)
        `CHK({vectorIrq, resumeNext}, {expVec, ~expVec})
        far.setReq(6'h00);
    endtask
////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        haltExec = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        `CHK({pinOutEnable, cpuClkEn, mainOscEn, sub2OscEn, sub1OscEn}, 5'h01)
        @(posedge clk) rst_n <= 1'b1;
        checkBoot(0);
        `CHK(rv, 96'h040200FF00CF0C0000000000)
        $display("test boot done");
        for (int i = 0; i < 8; i++) begin
            haltNow();
            wake({3'b010, i[2:0]}, i[1] & (~i[2] | i[0]));
        end
        haltNow();
        wake(6'b100000, 1'b1);
        $display("test wake done");
        haltNow();
        far.setReq(6'b011111);
        repeat (20) @(posedge clk);
        #1;
        `CHK({cpuClkEn, portLatchHold, vectorIrq, resumeNext}, 4'h4)
        far.setReq(6'h00);
        fork
            far.pinReset();
            begin
                repeat (10) @(posedge clk);
                #1;
                `CHK({ramRetain, coreResetN, pinOutEnable, mainOscEn, oscEn}, 5'h11)
            end
        join
        checkBoot(0);
        `CHK(ramRetain, 1'b0)
        $display("test reset in halt done");
        far.dogBite();
        #1;
        `CHK(wdN, 1'b0)
        repeat (3) @(posedge clk);
        #1;
        `CHK({wdN, pinOutEnable, coreResetN}, 3'h4)
        // Three edges have passed since the overflow was taken
        checkBoot(3);
        $display("test watchdog done");
        complete_run();
    end
endmodule
`default_nettype wire

// File: dv/hrs_far_side.sv
// Far-side model: reset pin, watchdog, interrupt controller and vector memory.
// Assumes its tasks are called from a process synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "hrs_defs.svh"
module hrs_far_side #(
    parameter logic [15:0] VEC = 16'h1A2B
) (
    input wire logic clk,
    input wire logic [15:0] vecAddr,
    output logic [7:0] vecData,
    output logic resetPinN,
    output logic watchdogOverflow,
    output logic [5:0] req
);
////////////////////////////////////////////////////////////////////////
    // vector bytes at 0000H and 0001H
    always_comb begin
        case (vecAddr)
            16'h0000: vecData = VEC[7:0];
            16'h0001: vecData = VEC[15:8];
            // Unmapped reads return a changing pattern, never a stale byte
            default: vecData = ~vecAddr[7:0];
        endcase
    end
    initial begin
        resetPinN = 1'b1;
        watchdogOverflow = 1'b0;
        req = 6'h00;
    end
////////////////////////////////////////////////////////////////////////
    // pin held low for the minimum time
    task automatic pinReset();
        @(posedge clk) resetPinN <= 1'b0;
        repeat (`HRS_RST_MIN_CYCLES) @(posedge clk);
        resetPinN <= 1'b1;
    endtask
    task automatic dogBite();
        @(posedge clk) watchdogOverflow <= 1'b1;
        @(posedge clk) watchdogOverflow <= 1'b0;
    endtask
    // Order {nmi, irq, mask, priority, acceptEnable, inService}
    task automatic setReq(input logic [5:0] r);
        @(posedge clk) req <= r;
    endtask
endmodule
`default_nettype wire

// File: rtl/halt_and_reset_sequencer.sv
// Halt state and reset sequence control of a small microcontroller core.
// Assumes CPU, interrupt controller and watchdog share clk; reset pin is asynchronous.
// How it works
// - Halt gates CPU clock, oscillator keeps running
// - Port latches hold value while halted
// - Peripheral clocks stay enabled during halt
// - Unmasked request ends halt; vector or resume
// - Wait 8 clocks vectored, 2 resuming
// - Non-maskable request always wakes and vectors
// - Reset during halt ends it, vectors
// - Mask and priority decide service or resume
// - Reset from pin low or watchdog overflow
// - PC loaded from vector at 0000H/0001H
// - Pins tri-stated in reset and stabilisation
// - Stabilisation wait after pin release
// - Watchdog reset self-releases, same wait
// - Watchdog overflow driven on active-low pin
// - Main and subclock2 stop in reset
// - CPU clock control resets to 04H
// - Status word, ports, modes, pull-ups reset values
// - Size selects and clock outputs reset values
// - Timer0 counter and controls cleared
// - Reset during halt keeps RAM contents
// - In-service flag 0 means higher priority active
`timescale 1ns/10ps
`default_nettype none
`include "hrs_defs.svh"
module halt_and_reset_sequencer
    import hrs_pkg::*;
#(
    parameter int STAB_CYCLES = `HRS_STAB_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic resetPinN,
    input wire logic watchdogOverflow,
    input wire logic haltExec,
    input wire logic irqRequest,
    input wire logic irq_mask_flag,
    input wire logic irq_priority_level_flag,
    input wire logic irq_accept_enable,
    input wire logic in_service_priority_flag,
    input wire logic nmiRequest,
    input wire logic [7:0] vecData,
    output logic [15:0] vecAddr,
    output logic cpuClkEn,
    output logic periphClkEn,
    output logic oscEn,
    output logic mainOscEn,
    output logic sub2OscEn,
    output logic sub1OscEn,
    output logic pinOutEnable,
    output logic portLatchHold,
    output logic ramRetain,
    output logic coreResetN,
    output logic pcLoad,
    output logic [15:0] pcValue,
    output logic vectorIrq,
    output logic resumeNext,
    output logic watchdog_overflow_outN,
    output logic [7:0] cpu_clock_control,
    output logic [7:0] program_status_word,
    output logic [7:0] portLatchRst,
    output logic [7:0] portModeRst,
    output logic [7:0] pullUpRst,
    output logic [7:0] memory_size_select,
    output logic [7:0] expansion_ram_size_select,
    output logic [7:0] clkOutSelect,
    output logic [7:0] sub2Control,
    output logic [15:0] timer0_count,
    output logic [7:0] timer0Control
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; first stage feeds only the second
    logic pinMeta_q, pinSync_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
        end else begin
            pinMeta_q <= resetPinN;
            pinSync_q <= pinMeta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    hrs_state_t state_q, state_d;
    logic [31:0] cnt_q, cnt_d;
    logic [7:0] vecLo_q, vecLo_d;
    logic [15:0] pc_q, pc_d;
    logic fromHalt_q, fromHalt_d;
    logic wakeVect_q, wakeVect_d;
    logic wdtPulse_q, wdtPulse_d;
    logic pcLoad_q, pcLoad_d;
    logic vectorIrq_q, vectorIrq_d;
    logic resume_q, resume_d;
    logic maskWake, maskService, resetReq;

    assign resetReq = !pinSync_q || watchdogOverflow;
    assign maskWake = irqRequest && !irq_mask_flag;
    assign maskService = irq_priority_level_flag ? (irq_accept_enable && in_service_priority_flag)
                                                 : irq_accept_enable;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        vecLo_d = vecLo_q;
        pc_d = pc_q;
        fromHalt_d = fromHalt_q;
        wakeVect_d = wakeVect_q;
        wdtPulse_d = 1'b0;
        pcLoad_d = 1'b0;
        vectorIrq_d = 1'b0;
        resume_d = 1'b0;
        if (resetReq) begin
            if (state_q == HRS_HALT) begin
                fromHalt_d = 1'b1;
            end
            wdtPulse_d = watchdogOverflow;
            state_d = HRS_RESET;
            cnt_d = 32'h0;
        end else begin
            case (state_q)
                HRS_RESET: begin
                    state_d = HRS_STAB;
                    cnt_d = 32'h0;
                end
                HRS_STAB: begin
                    if (cnt_q >= 32'(STAB_CYCLES - 1)) begin
                        state_d = HRS_VECLO;
                    end else begin
                        cnt_d = cnt_q + 32'h1;
                    end
                end
                HRS_VECLO: begin
                    vecLo_d = vecData;
                    state_d = HRS_VECHI;
                end
                HRS_VECHI: begin
                    pc_d = {vecData, vecLo_q};
                    pcLoad_d = 1'b1;
                    fromHalt_d = 1'b0;
                    state_d = HRS_RUN;
                end
                HRS_RUN: begin
                    if (haltExec) begin
                        state_d = HRS_HALT;
                    end
                end
                HRS_HALT: begin
                    if (nmiRequest || maskWake) begin
                        wakeVect_d = nmiRequest || maskService;
                        cnt_d = 32'h0;
                        state_d = HRS_WAKE;
                    end
                end
                HRS_WAKE: begin
                    if (cnt_q >= 32'(wakeVect_q ? `HRS_WAIT_VECT - 4'h1 : `HRS_WAIT_NEXT - 4'h1)) begin
                        vectorIrq_d = wakeVect_q;
                        resume_d = !wakeVect_q;
                        state_d = HRS_RUN;
                    end else begin
                        cnt_d = cnt_q + 32'h1;
                    end
                end
                default: begin
                    state_d = HRS_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= HRS_RESET;
            cnt_q <= 32'h0;
            vecLo_q <= 8'h00;
            pc_q <= 16'h0000;
            fromHalt_q <= 1'b0;
            wakeVect_q <= 1'b0;
            wdtPulse_q <= 1'b0;
            pcLoad_q <= 1'b0;
            vectorIrq_q <= 1'b0;
            resume_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            vecLo_q <= vecLo_d;
            pc_q <= pc_d;
            fromHalt_q <= fromHalt_d;
            wakeVect_q <= wakeVect_d;
            wdtPulse_q <= wdtPulse_d;
            pcLoad_q <= pcLoad_d;
            vectorIrq_q <= vectorIrq_d;
            resume_q <= resume_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    logic inReset;
    assign inReset = (state_q == HRS_RESET);
    assign vecAddr = (state_q == HRS_VECHI) ? `HRS_VEC_HI_ADDR : `HRS_VEC_LO_ADDR;
    // CPU clock gated in halt and sequence
    assign cpuClkEn = (state_q == HRS_RUN);
    assign periphClkEn = !inReset;
    assign oscEn = 1'b1;
    assign mainOscEn = !inReset;
    assign sub2OscEn = !inReset;
    assign sub1OscEn = 1'b1;
    assign pinOutEnable = !(inReset || state_q == HRS_STAB);
    assign portLatchHold = (state_q == HRS_HALT) || (state_q == HRS_WAKE);
    assign ramRetain = fromHalt_q;
    assign coreResetN = !(inReset || state_q == HRS_STAB || state_q == HRS_VECLO || state_q == HRS_VECHI);
    assign pcLoad = pcLoad_q;
    assign pcValue = pc_q;
    assign vectorIrq = vectorIrq_q;
    assign resumeNext = resume_q;
    assign watchdog_overflow_outN = !wdtPulse_q;
    assign cpu_clock_control = `HRS_RST_CPU_CLK;
    assign program_status_word = `HRS_RST_STATUS_WORD;
    assign portLatchRst = `HRS_RST_PORT_LATCH;
    assign portModeRst = `HRS_RST_PORT_MODE;
    assign pullUpRst = `HRS_RST_PULLUP;
    assign memory_size_select = `HRS_RST_MEM_SIZE;
    assign expansion_ram_size_select = `HRS_RST_XRAM_SIZE;
    assign clkOutSelect = `HRS_RST_CLKOUT_SEL;
    assign sub2Control = `HRS_RST_SUB2_CTRL;
    assign timer0_count = `HRS_RST_TIMER0_COUNT;
    assign timer0Control = `HRS_RST_TIMER0_CTRL;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_wakeStart;
        state_q == HRS_HALT && !resetReq && (nmiRequest || maskWake);
    endsequence

    // Eight wait cycles free of reset; a reset inside the wait aborts the wake
    sequence s_quietVect;
        (!resetReq)[*8];
    endsequence

    // Pulses are registered, so they show one edge after the last wait cycle
    a_nmi_vectors: assert property (@(posedge clk) disable iff (!rst_n)
        (s_wakeStart and nmiRequest) |-> ##1 s_quietVect ##1 vectorIrq)
        else $error("NMI wake did not vector after 8 clocks");
    a_irq_vectors: assert property (@(posedge clk) disable iff (!rst_n)
        (s_wakeStart and !nmiRequest && maskService) |-> ##1 s_quietVect ##1 vectorIrq)
        else $error("Serviced wake did not vector after 8 clocks");
    a_resume_wait: assert property (@(posedge clk) disable iff (!rst_n)
        (s_wakeStart and !nmiRequest && !maskService) |-> ##1 (!resetReq)[*2] ##1 resumeNext)
        else $error("Resume did not follow 2 clocks after wake");
    a_masked_stays: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == HRS_HALT && !resetReq && !nmiRequest && !maskWake) |=> state_q == HRS_HALT)
        else $error("Masked request left halt");
    a_halt_noclk: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == HRS_HALT |-> !cpuClkEn && periphClkEn && portLatchHold)
        else $error("CPU clock running in halt");
    a_reset_hiz: assert property (@(posedge clk) disable iff (!rst_n)
        resetReq |=> !pinOutEnable && !mainOscEn && sub1OscEn)
        else $error("Pins driven or osc wrong in reset");
    a_stab_pins: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == HRS_STAB |-> !pinOutEnable && !cpuClkEn && !coreResetN)
        else $error("Pins or core released during stabilisation");
    a_halt_reset: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == HRS_HALT && resetReq) |=> state_q == HRS_RESET && ramRetain)
        else $error("Reset in halt not honoured");
    a_vector_load: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == HRS_VECHI && !resetReq) |=> pcLoad && pcValue == {$past(vecData), $past(vecLo_q)})
        else $error("PC not loaded from vector");
    a_wdt_pin: assert property (@(posedge clk) disable iff (!rst_n)
        watchdogOverflow |=> !watchdog_overflow_outN)
        else $error("Watchdog overflow not on pin");
    a_wdt_release: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(watchdogOverflow) && pinSync_q && state_q == HRS_RESET) |=> state_q == HRS_STAB)
        else $error("Watchdog reset did not release");

endmodule
`default_nettype wire

// File: rtl/hrs_defs.svh
// Constants for the halt and reset sequencer: reset values and timing counts.
// Assumes a 100 MHz system clock; included by its bare name.
`ifndef HRS_DEFS_SVH
`define HRS_DEFS_SVH
`define HRS_CLK_HZ 100000000
`define HRS_STAB_TIME_MS 250
`define HRS_STAB_CYCLES ((`HRS_CLK_HZ / 1000) * `HRS_STAB_TIME_MS)
`define HRS_RST_MIN_US 10
`define HRS_RST_MIN_CYCLES ((`HRS_CLK_HZ / 1000000) * `HRS_RST_MIN_US)
`define HRS_WAIT_VECT 4'h8
`define HRS_WAIT_NEXT 4'h2
`define HRS_VEC_LO_ADDR 16'h0000
`define HRS_VEC_HI_ADDR 16'h0001
`define HRS_RST_CPU_CLK 8'h04
`define HRS_RST_STATUS_WORD 8'h02
`define HRS_RST_PORT_LATCH 8'h00
`define HRS_RST_PORT_MODE 8'hFF
`define HRS_RST_PULLUP 8'h00
`define HRS_RST_MEM_SIZE 8'hCF
`define HRS_RST_XRAM_SIZE 8'h0C
`define HRS_RST_CLKOUT_SEL 8'h00
`define HRS_RST_SUB2_CTRL 8'h00
`define HRS_RST_TIMER0_COUNT 16'h0000
`define HRS_RST_TIMER0_CTRL 8'h00
`endif

// File: rtl/hrs_pkg.sv
// Types shared by the halt and reset sequencer.
// Assumes the defs header is compiled with it.
package hrs_pkg;
    typedef enum logic [2:0] {
        HRS_RESET   = 3'h0,
        HRS_STAB    = 3'h1,
        HRS_VECLO   = 3'h2,
        HRS_VECHI   = 3'h3,
        HRS_RUN     = 3'h4,
        HRS_HALT    = 3'h5,
        HRS_WAKE    = 3'h6
    } hrs_state_t;
endpackage
